//--- src/bpo_pkg.sv
package bpo_pkg;

  // ****************************************
  // Timing constants
  // ****************************************

  // Clock period in picoseconds, 100 MHz core clock.
  localparam int CLK_PERIOD_PS = 10000;
  // Typical blanking interval after each pulse start, in nanoseconds.
  localparam int BLANK_TIME_NS = 375;
  // Blanking length in cycles, rounded down as a longest time, at least one.
  localparam int BLANK_CYCLES_RAW = (BLANK_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int BLANK_CYCLES = (BLANK_CYCLES_RAW < 1) ? 1 : BLANK_CYCLES_RAW;

  // ****************************************
  // Reset values
  // ****************************************

  localparam logic RST_TOGGLE = 1'b0;
  localparam logic RST_FAULT = 1'b0;

  // Fault sequencer states.
  typedef enum logic [1:0] {
    BPO_RUN = 2'b00,
    BPO_WAIT_FULL = 2'b01,
    BPO_DISCHARGE = 2'b10
  } bpo_fault_e;

  // Comparator trips, already synchronous to core_clk.
  typedef struct packed {
    logic pwm_trip;
    logic climit_trip;
    logic ocur_trip;
  } bpo_trip_s;

  // Soft-start and supply status.
  typedef struct packed {
    logic ss_full;
    logic ss_empty;
    logic undervoltage_lockout;
  } bpo_supply_s;

endpackage

//--- src/bpo_steer.sv
`timescale 1ns/100ps

// Summary of operation
// - Outputs low throughout oscillator discharge.
// - Discharge phase sets dead time between pulses.
// - Clock pulse end drives selected outputs high.
// - In-phase mode: both outputs switch together.
// - Alternating mode: each output every other cycle.
// - Pulse ends on PWM, limit or overcurrent.
// - Ramp above control level ends pulse.
// - PWM trip ignored during blanking interval.
// - Limit trip blanked, ends pulse, no fault.
// - Overcurrent unblanked, sets fault, outputs low.
// - Fault clears after soft-start empty, current low.
// - Fault in soft-start waits full charge first.
// - Lockout holds both outputs low.
module bpo_steer #(
  parameter int BLANK_LEN = bpo_pkg::BLANK_CYCLES,
  parameter bit ALTERNATE = 1'b1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic osc_clk_pulse,
  input wire bpo_pkg::bpo_trip_s trips,
  input wire bpo_pkg::bpo_supply_s supply,
  output logic out_a,
  output logic out_b,
  output logic fault_latch,
  output logic ss_discharge,
  output logic blank_active
);
  import bpo_pkg::*;

  localparam int CW = $clog2(BLANK_LEN + 1);

  initial begin
    if (BLANK_LEN < 1) begin
      $error("BLANK_LEN must be at least one cycle.");
    end
  end

  // ****************************************
  // Pulse start and blanking
  // ****************************************

  logic clk_prev;
  logic toggle;
  logic [CW-1:0] blank_cnt;
  bpo_fault_e fstate;
  bpo_fault_e next_fstate;

  // Falling edge of the clock pulse starts a pulse; inputs are synchronous.
  wire pulse_start = clk_prev & ~osc_clk_pulse;
  // The start cycle itself is blanked, so the counter holds the rest.
  wire cnt_busy = (blank_cnt != '0);
  wire blanked = pulse_start | cnt_busy;
  wire [CW-1:0] blank_load = CW'(BLANK_LEN - 1);
  wire [CW-1:0] next_blank_cnt = pulse_start ? blank_load :
    (cnt_busy ? blank_cnt - 1'b1 : blank_cnt);
  wire run_ok = ~fault_latch & ~supply.undervoltage_lockout;
  // Overcurrent is never blanked; the other two only after blanking.
  wire qual_pwm = trips.pwm_trip & ~blanked;
  wire qual_lim = trips.climit_trip & ~blanked;
  wire terminate = qual_pwm | qual_lim | trips.ocur_trip;
  // A pulse that starts while overcurrent is seen ends at once (zero duty).
  wire start_ok = pulse_start & run_ok & ~trips.ocur_trip;
  wire sel_a = ~ALTERNATE | ~toggle;
  wire sel_b = ~ALTERNATE | toggle;

  // Edge memory samples every cycle; blanking counter restarts at each pulse start.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      clk_prev <= 1'b0;
      blank_cnt <= '0;
    end else begin
      clk_prev <= osc_clk_pulse;
      blank_cnt <= next_blank_cnt;
    end
  end

  // Toggle advances on each clock pulse so outputs alternate.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      toggle <= RST_TOGGLE;
    end else if (pulse_start) begin
      toggle <= ~toggle;
    end
  end

  // ****************************************
  // Output drive
  // ****************************************

  // Clock high, lockout, fault or a qualified trip force outputs low.
  // Termination acts in the cycle the trip is seen, not one later.
  wire kill = osc_clk_pulse | ~run_ok | terminate;
  wire next_a = ~kill & (start_ok ? sel_a : out_a);
  wire next_b = ~kill & (start_ok ? sel_b : out_b);

  // Registered drivers for the gate stage.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      out_a <= 1'b0;
      out_b <= 1'b0;
      blank_active <= 1'b0;
    end else begin
      out_a <= next_a;
      out_b <= next_b;
      blank_active <= (next_blank_cnt != '0);
    end
  end

  // ****************************************
  // Fault latch and soft-start sequencing
  // ****************************************

  // Hiccup: wait for full charge, then discharge, then release.
  always_comb begin
    next_fstate = fstate;
    case (fstate)
      BPO_RUN: begin
        if (trips.ocur_trip) begin
          next_fstate = supply.ss_full ? BPO_DISCHARGE : BPO_WAIT_FULL;
        end
      end
      BPO_WAIT_FULL: begin
        if (supply.ss_full) begin
          next_fstate = BPO_DISCHARGE;
        end
      end
      BPO_DISCHARGE: begin
        if (supply.ss_empty & ~trips.ocur_trip) begin
          next_fstate = BPO_RUN;
        end
      end
      default: begin
        next_fstate = BPO_RUN;
      end
    endcase
  end

  // Latch and discharge come from state so set beats any release.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fstate <= BPO_RUN;
      fault_latch <= RST_FAULT;
      ss_discharge <= 1'b0;
    end else begin
      fstate <= next_fstate;
      fault_latch <= (next_fstate != BPO_RUN);
      ss_discharge <= (next_fstate == BPO_DISCHARGE);
    end
  end

  // ****************************************
  // Checks
  // ****************************************

  AST_CLK_LOW: assert property (@(posedge core_clk) disable iff (sys_rst)
    osc_clk_pulse |=> !out_a && !out_b)
    else $error("Output high after clock pulse.");

  AST_START: assert property (@(posedge core_clk) disable iff (sys_rst)
    start_ok && !trips.pwm_trip && !trips.climit_trip |=> out_a || out_b)
    else $error("No pulse after clock end.");

  AST_OCUR_LOW: assert property (@(posedge core_clk) disable iff (sys_rst)
    trips.ocur_trip |=> !out_a && !out_b && fault_latch)
    else $error("Overcurrent did not kill outputs.");

  AST_LIM_NOFAULT: assert property (@(posedge core_clk) disable iff (sys_rst)
    fstate == BPO_RUN && trips.climit_trip && !trips.ocur_trip |=> !fault_latch)
    else $error("Current limit set fault.");

  AST_BLANK_PWM: assert property (@(posedge core_clk) disable iff (sys_rst)
    start_ok && !trips.ocur_trip && !trips.climit_trip ##0 !osc_clk_pulse[*1]
    ##1 (trips.pwm_trip && !trips.ocur_trip && !trips.climit_trip
    && !osc_clk_pulse) |=> out_a || out_b || BLANK_LEN < 2)
    else $error("PWM trip not blanked.");

  AST_FAULT_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
    fault_latch && !supply.ss_empty |=> fault_latch)
    else $error("Fault released before soft-start empty.");

  AST_HICCUP: assert property (@(posedge core_clk) disable iff (sys_rst)
    fstate == BPO_WAIT_FULL && !supply.ss_full |=> !ss_discharge)
    else $error("Discharge before full charge.");

  AST_UNDERVOLTAGE_LOCKOUT: assert property (@(posedge core_clk) disable iff (sys_rst)
    supply.undervoltage_lockout |=> !out_a && !out_b)
    else $error("Output high in lockout.");

  AST_ALT: assert property (@(posedge core_clk) disable iff (sys_rst)
    ALTERNATE |-> !(out_a && out_b))
    else $error("Both outputs high in alternating mode.");

  AST_TOGGLE: assert property (@(posedge core_clk) disable iff (sys_rst)
    pulse_start |=> toggle != $past(toggle))
    else $error("Toggle did not advance.");

endmodule

//--- verif/bpo_gate_model.sv
`timescale 1ns/100ps
// ****************************************
// Gate driver stage
// ****************************************
module bpo_gate_model (
  input wire logic core_clk,
  input wire logic gate_a,
  input wire logic gate_b,
  output logic clash
);
  // A real stage gives no feedback, so the model only records overlap.
  initial clash = 1'h0;
  // Both switches on at once would short the transformer halves.
  always @(posedge core_clk) begin
    if (gate_a && gate_b) begin
      clash <= 1'h1;
    end
  end
endmodule

//--- verif/tb.sv
`timescale 1ns/100ps
module tb;
  import bpo_pkg::*;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic osc = 1'h1;
  bpo_trip_s trips = '0;
  bpo_supply_s supply = '0;
  logic out_a, out_b, fault_latch, ss_discharge, blank_active, clash;
  logic pa, pb;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int i;

  // Blanking is shortened to two cycles to keep the run brief.
  bpo_steer #(.BLANK_LEN(2), .ALTERNATE(1'h1)) DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .osc_clk_pulse(osc),
    .trips(trips), .supply(supply), .out_a(out_a), .out_b(out_b),
    .fault_latch(fault_latch), .ss_discharge(ss_discharge),
    .blank_active(blank_active));
  // Second copy in the in-phase variant sees the same stimulus.
  bpo_steer #(.BLANK_LEN(2), .ALTERNATE(1'h0)) DUT_PH (
    .core_clk(core_clk), .sys_rst(sys_rst), .osc_clk_pulse(osc),
    .trips(trips), .supply(supply), .out_a(pa), .out_b(pb),
    .fault_latch(), .ss_discharge(), .blank_active());
  bpo_gate_model gate (.core_clk(core_clk), .gate_a(out_a),
    .gate_b(out_b), .clash(clash));

  // Free-running 100 MHz clock.
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // Hang guard; the whole run needs under fifty cycles.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cyc;
    @(posedge core_clk);
  endtask

  task automatic chk(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask

  // One discharge cycle, then release with the given trips applied.
  task automatic start_pulse(input bpo_trip_s t);
    cyc;
    osc <= 1'h1;
    cyc;
    osc <= 1'h0;
    trips <= t;
    #1;
    chk(out_a | out_b, 1'h0, "output high in discharge");
    cyc;
    #1;
  endtask

  task automatic t_alternate;
    start_pulse('0);
    chk(out_a, 1'h1, "first pulse not on a");
    chk(out_b, 1'h0, "b on in a cycle");
    chk(pa & pb, 1'h1, "in-phase outputs not together");
    start_pulse('0);
    chk(out_b, 1'h1, "second pulse not on b");
    chk(out_a, 1'h0, "a on in b cycle");
    chk(pa & pb, 1'h1, "in-phase pulse missing");
  endtask

  // The trip is held from pulse start, so only blanking keeps it alive.
  task automatic t_blank(input bpo_trip_s t, input logic side_a);
    start_pulse(t);
    chk(blank_active, 1'h1, "blanking not open");
    chk(out_a, side_a, "pulse lost to blanked trip");
    cyc;
    #1;
    chk(out_a | out_b, 1'h1, "trip seen in blanking");
    cyc;
    #1;
    chk(out_a | out_b, 1'h0, "trip did not end pulse");
    chk(fault_latch, 1'h0, "fault from plain trip");
    cyc;
    trips <= '0;
  endtask

  // Overcurrent during soft-start, then the full hiccup sequence.
  task automatic t_fault;
    start_pulse(3'h1);
    chk(out_a | out_b, 1'h0, "output under overcurrent");
    chk(fault_latch, 1'h1, "fault not set");
    chk(ss_discharge, 1'h0, "discharge before full");
    start_pulse(3'h1);
    chk(out_a | out_b, 1'h0, "pulse while faulted");
    cyc;
    trips <= '0;
    supply <= 3'h4;
    for (i = 0; i < 8 && ss_discharge !== 1'h1; i++) begin
      cyc;
      #1;
    end
    chk(ss_discharge, 1'h1, "no discharge at full");
    chk(fault_latch, 1'h1, "fault cleared too soon");
    cyc;
    supply <= 3'h2;
    for (i = 0; i < 8 && fault_latch !== 1'h0; i++) begin
      cyc;
      #1;
    end
    chk(fault_latch, 1'h0, "fault not released");
    cyc;
    supply <= '0;
  endtask

  task automatic t_lockout;
    start_pulse('0);
    chk(out_a | out_b, 1'h1, "no restart after fault");
    cyc;
    supply <= 3'h1;
    cyc;
    #1;
    chk(out_a | out_b, 1'h0, "lockout kept output");
    start_pulse('0);
    chk(out_a | out_b, 1'h0, "pulse in lockout");
    cyc;
    supply <= '0;
  endtask

  initial begin
    repeat (4) cyc;
    sys_rst <= 1'h0;
    #1;
    chk(out_a | out_b | fault_latch, 1'h0, "not idle after reset");
    t_alternate;
    t_blank(3'h4, 1'h1);
    t_blank(3'h2, 1'h0);
    t_fault;
    t_lockout;
    cyc;
    #1;
    chk(clash, 1'h0, "outputs overlapped");
    test_done();
  end
endmodule
